/* hw/gpcfg_params.svh */
// Offsets, field positions, reset values and timing counts for pad config
`ifndef GPCFG_PARAMS_SVH
`define GPCFG_PARAMS_SVH

`define GPCFG_OFS_TWO_MILLIAMP_DRIVE_BIT      12'h500
`define GPCFG_OFS_FOUR_MILLIAMP_DRIVE_BIT      12'h504
`define GPCFG_OFS_EIGHT_MILLIAMP_DRIVE_BIT      12'h508
`define GPCFG_OFS_ODR       12'h50C
`define GPCFG_OFS_PUR       12'h510
`define GPCFG_OFS_PDR       12'h514
`define GPCFG_OFS_SLR       12'h518
`define GPCFG_OFS_DEN       12'h51C
`define GPCFG_OFS_DIR       12'h400
`define GPCFG_OFS_AFSEL     12'h420

`define GPCFG_PIN_MSB       7
`define GPCFG_ADDR_MSB      11

`define GPCFG_RST_TWO_MILLIAMP_DRIVE_BIT      8'hFF
`define GPCFG_RST_FOUR_MILLIAMP_DRIVE_BIT      8'h00
`define GPCFG_RST_EIGHT_MILLIAMP_DRIVE_BIT      8'h00
`define GPCFG_RST_ODR       8'h00
`define GPCFG_RST_PUR       8'hFF
`define GPCFG_RST_PDR       8'h00
`define GPCFG_RST_SLR       8'h00
`define GPCFG_RST_DEN       8'hFF
`define GPCFG_RST_DIR       8'h00
`define GPCFG_RST_AFSEL     8'h00

`define GPCFG_PAD_LATENCY   2

`endif

/* hw/gpcfg_pkg.sv */
// Types shared by the pad configuration block
package gpcfg_pkg;
    typedef logic [7:0] gpcfg_pins_t;
    typedef enum logic [1:0] {
        GPCFG_DRV_2MA,
        GPCFG_DRV_4MA,
        GPCFG_DRV_8MA,
        GPCFG_DRV_NONE
    } gpcfg_drive_t;
endpackage

/* hw/gpcfg_pad_if.sv */
// Per-pin pad control bundle between the register file and the pad stage
`timescale 1ns/1ps
`default_nettype none
interface gpcfg_pad_if;
    logic [7:0] two_milliamp_drive_bit;
    logic [7:0] four_milliamp_drive_bit;
    logic [7:0] eight_milliamp_drive_bit;
    logic [7:0] odr;
    logic [7:0] pur;
    logic [7:0] pdr;
    logic [7:0] slr;
    logic [7:0] input_buffer_bit;
    logic [7:0] dir;
    logic [7:0] afsel;
    modport src (output two_milliamp_drive_bit, four_milliamp_drive_bit, eight_milliamp_drive_bit, odr, pur, pdr, slr, input_buffer_bit, dir, afsel);
    modport dst (input  two_milliamp_drive_bit, four_milliamp_drive_bit, eight_milliamp_drive_bit, odr, pur, pdr, slr, input_buffer_bit, dir, afsel);
endinterface
`default_nettype wire

/* hw/gpcfg_pad_stage.sv */
// Pad stage: registers the pad controls and decodes per-pin pad settings
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pad_stage (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Register values
    gpcfg_pad_if.dst               cfg,
    // Pad controls
    output logic [7:0]             pad_two_milliamp_drive_bit,
    output logic [7:0]             pad_four_milliamp_drive_bit,
    output logic [7:0]             pad_eight_milliamp_drive_bit,
    output logic [7:0]             pad_open_drain,
    output logic [7:0]             pad_od_output,
    output logic [7:0]             pad_pull_up,
    output logic [7:0]             pad_pull_down,
    output logic [7:0]             pad_slew_limit,
    output logic [7:0]             pad_input_enable,
    output logic [7:0]             pad_periph_ctrl
);
    import gpcfg_pkg::*;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            wire slew_nxt;
            wire odo_nxt;
            assign slew_nxt = cfg.slr[i] & cfg.eight_milliamp_drive_bit[i];
            assign odo_nxt  = cfg.odr[i] & cfg.dir[i];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pad_two_milliamp_drive_bit[i]         <= 1'b1;
                    pad_four_milliamp_drive_bit[i]         <= 1'b0;
                    pad_eight_milliamp_drive_bit[i]         <= 1'b0;
                    pad_open_drain[i]   <= 1'b0;
                    pad_od_output[i]    <= 1'b0;
                    pad_pull_up[i]      <= 1'b1;
                    pad_pull_down[i]    <= 1'b0;
                    pad_slew_limit[i]   <= 1'b0;
                    pad_input_enable[i] <= 1'b1;
                    pad_periph_ctrl[i]  <= 1'b0;
                end else begin
                    // Second stage of the two-cycle pad update
                    pad_two_milliamp_drive_bit[i]         <= cfg.two_milliamp_drive_bit[i];
                    pad_four_milliamp_drive_bit[i]         <= cfg.four_milliamp_drive_bit[i];
                    pad_eight_milliamp_drive_bit[i]         <= cfg.eight_milliamp_drive_bit[i];
                    pad_open_drain[i]   <= cfg.odr[i];
                    pad_od_output[i]    <= odo_nxt;
                    pad_pull_up[i]      <= cfg.pur[i];
                    pad_pull_down[i]    <= cfg.pdr[i];
                    pad_slew_limit[i]   <= slew_nxt;
                    pad_input_enable[i] <= cfg.input_buffer_bit[i];
                    pad_periph_ctrl[i]  <= cfg.afsel[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/gpcfg_top.sv */
// APB register file for per-pin pad configuration of one 8-bit port
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_params.svh"

// Operation
// - Writing 2 mA bit clears 4/8 mA
// - Writing 4 mA bit clears 2/8 mA
// - Writing 8 mA bit clears 2/4 mA
// - Drive and pull changes reach pads second cycle
// - Open-drain bit selects open-drain pad, resets 0
// - Open drain: direction picks input or output
// - Pull-up write clears pull-down, resets all ones
// - Pull-down write clears pull-up, resets zero
// - Input buffers enabled after reset
// - Alternate-function bit hands pin to peripheral
module gpcfg_top (
    // APB slave
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Pad controls
    output logic [7:0]                 pad_two_milliamp_drive_bit,
    output logic [7:0]                 pad_four_milliamp_drive_bit,
    output logic [7:0]                 pad_eight_milliamp_drive_bit,
    output logic [7:0]                 pad_open_drain,
    output logic [7:0]                 pad_od_output,
    output logic [7:0]                 pad_pull_up,
    output logic [7:0]                 pad_pull_down,
    output logic [7:0]                 pad_slew_limit,
    output logic [7:0]                 pad_input_enable,
    output logic [7:0]                 pad_periph_ctrl,
    // Drive summary for pin 0 only
    output gpcfg_pkg::gpcfg_drive_t    drive_sel_pin0
);
    import gpcfg_pkg::*;

    gpcfg_pins_t two_milliamp_drive_bit_r;
    gpcfg_pins_t four_milliamp_drive_bit_r;
    gpcfg_pins_t eight_milliamp_drive_bit_r;
    gpcfg_pins_t odr_r;
    gpcfg_pins_t pur_r;
    gpcfg_pins_t pdr_r;
    gpcfg_pins_t slr_r;
    gpcfg_pins_t den_r;
    gpcfg_pins_t dir_r;
    gpcfg_pins_t afsel_r;
    logic [31:0] prdata_r;

    gpcfg_pins_t two_milliamp_drive_bit_nxt;
    gpcfg_pins_t four_milliamp_drive_bit_nxt;
    gpcfg_pins_t eight_milliamp_drive_bit_nxt;
    gpcfg_pins_t pur_nxt;
    gpcfg_pins_t pdr_nxt;

    wire [11:0] ofs;
    wire        acc;
    wire        wr;
    wire        rd;
    wire        hit_two_milliamp_drive_bit;
    wire        hit_four_milliamp_drive_bit;
    wire        hit_eight_milliamp_drive_bit;
    wire        hit_odr;
    wire        hit_pur;
    wire        hit_pdr;
    wire        hit_slr;
    wire        hit_den;
    wire        hit_dir;
    wire        hit_afsel;
    wire        mapped;
    wire [7:0]  wbyte;
    wire [7:0]  set2;
    wire [7:0]  set4;
    wire [7:0]  set8;
    wire [7:0]  setpu;
    wire [7:0]  setpd;
    wire [7:0]  rsel;
    wire [31:0] prdata_nxt;

    wire        in_window;
    wire        aligned;
    wire        hit_any;
    wire        bad_acc;

    wire        we_two_milliamp_drive_bit;
    wire        we_four_milliamp_drive_bit;
    wire        we_eight_milliamp_drive_bit;
    wire        we_odr;
    wire        we_pur;
    wire        we_pdr;
    wire        we_slr;
    wire        we_den;
    wire        we_dir;
    wire        we_afsel;

    // Address decode
    assign ofs       = paddr[`GPCFG_ADDR_MSB:0];
    assign acc       = psel & penable;
    assign wr        = acc & pwrite;
    assign rd        = psel & ~penable & ~pwrite;
    assign hit_two_milliamp_drive_bit  = (ofs == `GPCFG_OFS_TWO_MILLIAMP_DRIVE_BIT);
    assign hit_four_milliamp_drive_bit  = (ofs == `GPCFG_OFS_FOUR_MILLIAMP_DRIVE_BIT);
    assign hit_eight_milliamp_drive_bit  = (ofs == `GPCFG_OFS_EIGHT_MILLIAMP_DRIVE_BIT);
    assign hit_odr   = (ofs == `GPCFG_OFS_ODR);
    assign hit_pur   = (ofs == `GPCFG_OFS_PUR);
    assign hit_pdr   = (ofs == `GPCFG_OFS_PDR);
    assign hit_slr   = (ofs == `GPCFG_OFS_SLR);
    assign hit_den   = (ofs == `GPCFG_OFS_DEN);
    assign hit_dir   = (ofs == `GPCFG_OFS_DIR);
    assign hit_afsel = (ofs == `GPCFG_OFS_AFSEL);

    // Address window, alignment and register hit
    assign in_window = (paddr[31:12] == 20'h00000);
    assign aligned   = (paddr[1:0] == 2'b00);
    assign hit_any   = hit_two_milliamp_drive_bit | hit_four_milliamp_drive_bit | hit_eight_milliamp_drive_bit | hit_odr | hit_pur |
                       hit_pdr | hit_slr | hit_den | hit_dir | hit_afsel;
    assign mapped    = in_window & aligned & hit_any;
    assign wbyte     = pwdata[`GPCFG_PIN_MSB:0];

    // Write enables per register
    assign we_two_milliamp_drive_bit   = wr & mapped & hit_two_milliamp_drive_bit;
    assign we_four_milliamp_drive_bit   = wr & mapped & hit_four_milliamp_drive_bit;
    assign we_eight_milliamp_drive_bit   = wr & mapped & hit_eight_milliamp_drive_bit;
    assign we_odr    = wr & mapped & hit_odr;
    assign we_pur    = wr & mapped & hit_pur;
    assign we_pdr    = wr & mapped & hit_pdr;
    assign we_slr    = wr & mapped & hit_slr;
    assign we_den    = wr & mapped & hit_den;
    assign we_dir    = wr & mapped & hit_dir;
    assign we_afsel  = wr & mapped & hit_afsel;

    // Ones written to each drive and pull register
    assign set2  = we_two_milliamp_drive_bit ? wbyte : 8'h00;
    assign set4  = we_four_milliamp_drive_bit ? wbyte : 8'h00;
    assign set8  = we_eight_milliamp_drive_bit ? wbyte : 8'h00;
    assign setpu = we_pur  ? wbyte : 8'h00;
    assign setpd = we_pdr  ? wbyte : 8'h00;

    // Drive select with companion clearing of the other two strengths
    always_comb begin
        two_milliamp_drive_bit_nxt = two_milliamp_drive_bit_r;
        four_milliamp_drive_bit_nxt = four_milliamp_drive_bit_r;
        eight_milliamp_drive_bit_nxt = eight_milliamp_drive_bit_r;
        if (wr && mapped && hit_two_milliamp_drive_bit) begin
            two_milliamp_drive_bit_nxt = wbyte;
            four_milliamp_drive_bit_nxt = four_milliamp_drive_bit_r & ~set2;
            eight_milliamp_drive_bit_nxt = eight_milliamp_drive_bit_r & ~set2;
        end
        if (wr && mapped && hit_four_milliamp_drive_bit) begin
            four_milliamp_drive_bit_nxt = wbyte;
            two_milliamp_drive_bit_nxt = two_milliamp_drive_bit_r & ~set4;
            eight_milliamp_drive_bit_nxt = eight_milliamp_drive_bit_r & ~set4;
        end
        if (wr && mapped && hit_eight_milliamp_drive_bit) begin
            eight_milliamp_drive_bit_nxt = wbyte;
            two_milliamp_drive_bit_nxt = two_milliamp_drive_bit_r & ~set8;
            four_milliamp_drive_bit_nxt = four_milliamp_drive_bit_r & ~set8;
        end
    end

    // Pull select, mutually exclusive per pin
    always_comb begin
        pur_nxt = pur_r;
        pdr_nxt = pdr_r;
        if (wr && mapped && hit_pur) begin
            pur_nxt = wbyte;
            pdr_nxt = pdr_r & ~setpu;
        end
        if (wr && mapped && hit_pdr) begin
            pdr_nxt = wbyte;
            pur_nxt = pur_r & ~setpd;
        end
    end

    // Two mA drive select; first stage of the pad update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            two_milliamp_drive_bit_r <= `GPCFG_RST_TWO_MILLIAMP_DRIVE_BIT;
        end else begin
            two_milliamp_drive_bit_r <= two_milliamp_drive_bit_nxt;
        end
    end

    // Four mA drive select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            four_milliamp_drive_bit_r <= `GPCFG_RST_FOUR_MILLIAMP_DRIVE_BIT;
        end else begin
            four_milliamp_drive_bit_r <= four_milliamp_drive_bit_nxt;
        end
    end

    // Eight mA drive select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eight_milliamp_drive_bit_r <= `GPCFG_RST_EIGHT_MILLIAMP_DRIVE_BIT;
        end else begin
            eight_milliamp_drive_bit_r <= eight_milliamp_drive_bit_nxt;
        end
    end

    // Pull-up select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pur_r <= `GPCFG_RST_PUR;
        end else begin
            pur_r <= pur_nxt;
        end
    end

    // Pull-down select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdr_r <= `GPCFG_RST_PDR;
        end else begin
            pdr_r <= pdr_nxt;
        end
    end

    // Open-drain select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odr_r <= `GPCFG_RST_ODR;
        end else if (we_odr) begin
            odr_r <= wbyte;
        end
    end

    // Slew limit select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slr_r <= `GPCFG_RST_SLR;
        end else if (we_slr) begin
            slr_r <= wbyte;
        end
    end

    // Digital input enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            den_r <= `GPCFG_RST_DEN;
        end else if (we_den) begin
            den_r <= wbyte;
        end
    end

    // Pin direction, feeds the open-drain output decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r <= `GPCFG_RST_DIR;
        end else if (we_dir) begin
            dir_r <= wbyte;
        end
    end

    // Alternate function select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afsel_r <= `GPCFG_RST_AFSEL;
        end else if (we_afsel) begin
            afsel_r <= wbyte;
        end
    end

    // Read mux
    assign rsel = hit_two_milliamp_drive_bit  ? two_milliamp_drive_bit_r  :
                  hit_four_milliamp_drive_bit  ? four_milliamp_drive_bit_r  :
                  hit_eight_milliamp_drive_bit  ? eight_milliamp_drive_bit_r  :
                  hit_odr   ? odr_r   :
                  hit_pur   ? pur_r   :
                  hit_pdr   ? pdr_r   :
                  hit_slr   ? slr_r   :
                  hit_den   ? den_r   :
                  hit_dir   ? dir_r   :
                  hit_afsel ? afsel_r : 8'h00;

    assign prdata_nxt = mapped ? {24'h000000, rsel} : 32'h00000000;

    // Read data registered in the setup cycle, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (rd) begin
            prdata_r <= prdata_nxt;
        end
    end

    // Zero wait states; error only in the access phase
    assign bad_acc = acc & ~mapped;
    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = bad_acc;

    // Per-pin drive summary for pin 0
    assign drive_sel_pin0 = eight_milliamp_drive_bit_r[0] ? GPCFG_DRV_8MA :
                            four_milliamp_drive_bit_r[0] ? GPCFG_DRV_4MA :
                            two_milliamp_drive_bit_r[0] ? GPCFG_DRV_2MA : GPCFG_DRV_NONE;

    // Register values handed to the pad stage
    gpcfg_pad_if cfg_bus ();
    assign cfg_bus.two_milliamp_drive_bit  = two_milliamp_drive_bit_r;
    assign cfg_bus.four_milliamp_drive_bit  = four_milliamp_drive_bit_r;
    assign cfg_bus.eight_milliamp_drive_bit  = eight_milliamp_drive_bit_r;
    assign cfg_bus.odr   = odr_r;
    assign cfg_bus.pur   = pur_r;
    assign cfg_bus.pdr   = pdr_r;
    assign cfg_bus.slr   = slr_r;
    assign cfg_bus.input_buffer_bit   = den_r;
    assign cfg_bus.dir   = dir_r;
    assign cfg_bus.afsel = afsel_r;

    // Second stage of the pad update
    gpcfg_pad_stage gpcfg_pad_stage_i (
        .pclk             (pclk),
        .presetn          (presetn),
        .cfg              (cfg_bus),
        .pad_two_milliamp_drive_bit         (pad_two_milliamp_drive_bit),
        .pad_four_milliamp_drive_bit         (pad_four_milliamp_drive_bit),
        .pad_eight_milliamp_drive_bit         (pad_eight_milliamp_drive_bit),
        .pad_open_drain   (pad_open_drain),
        .pad_od_output    (pad_od_output),
        .pad_pull_up      (pad_pull_up),
        .pad_pull_down    (pad_pull_down),
        .pad_slew_limit   (pad_slew_limit),
        .pad_input_enable (pad_input_enable),
        .pad_periph_ctrl  (pad_periph_ctrl)
    );
endmodule
`default_nettype wire

/* bench/gpcfg_chk.sv */
// Port checks for the pad configuration block
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_params.svh"
module gpcfg_chk (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Pads
    input wire logic [7:0]  pad_two_milliamp_drive_bit,
    input wire logic [7:0]  pad_four_milliamp_drive_bit,
    input wire logic [7:0]  pad_eight_milliamp_drive_bit,
    input wire logic [7:0]  pad_open_drain,
    input wire logic [7:0]  pad_od_output,
    input wire logic [7:0]  pad_pull_up,
    input wire logic [7:0]  pad_pull_down,
    input wire logic [7:0]  pad_slew_limit,
    input wire logic [7:0]  pad_input_enable,
    input wire logic [7:0]  pad_periph_ctrl
);
    wire logic              hit;
    assign hit = paddr[31:12] == 20'h0 && paddr[11:0] inside {
        `GPCFG_OFS_TWO_MILLIAMP_DRIVE_BIT, `GPCFG_OFS_FOUR_MILLIAMP_DRIVE_BIT, `GPCFG_OFS_EIGHT_MILLIAMP_DRIVE_BIT, `GPCFG_OFS_ODR,
        `GPCFG_OFS_PUR, `GPCFG_OFS_PDR, `GPCFG_OFS_SLR, `GPCFG_OFS_DEN,
        `GPCFG_OFS_DIR, `GPCFG_OFS_AFSEL};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_wr(ofs);
        psel && penable && pwrite && paddr == {20'h0, ofs};
    endsequence
    property lands(ofs, pad);
        acc_wr(ofs) |-> ##2 pad == $past(pwdata[7:0], 2);
    endproperty
    rst_pads_a: assert property ($rose(presetn) |->
        pad_two_milliamp_drive_bit == 8'hFF && pad_four_milliamp_drive_bit == 8'h00 && pad_eight_milliamp_drive_bit == 8'h00 &&
        pad_open_drain == 8'h00 && pad_pull_up == 8'hFF &&
        pad_pull_down == 8'h00 && pad_slew_limit == 8'h00 &&
        pad_input_enable == 8'hFF) else $error("pad reset values wrong");
    drive_onehot_a: assert property (((pad_two_milliamp_drive_bit & pad_four_milliamp_drive_bit) |
        (pad_two_milliamp_drive_bit & pad_eight_milliamp_drive_bit) | (pad_four_milliamp_drive_bit & pad_eight_milliamp_drive_bit)) == 8'h00)
        else $error("two drive strengths on one pin");
    pull_excl_a: assert property ((pad_pull_up & pad_pull_down) == 8'h00)
        else $error("pull up and down together");
    slew_gate_a: assert property ((pad_slew_limit & ~pad_eight_milliamp_drive_bit) == 8'h00)
        else $error("slew limit without eight mA drive");
    od_subset_a: assert property ((pad_od_output & ~pad_open_drain) == 8'h00)
        else $error("open drain output without open drain");
    two_ma_lat_a: assert property (lands(`GPCFG_OFS_TWO_MILLIAMP_DRIVE_BIT, pad_two_milliamp_drive_bit))
        else $error("two mA write not at pads");
    four_ma_lat_a: assert property (lands(`GPCFG_OFS_FOUR_MILLIAMP_DRIVE_BIT, pad_four_milliamp_drive_bit))
        else $error("four mA write not at pads");
    eight_ma_lat_a: assert property (lands(`GPCFG_OFS_EIGHT_MILLIAMP_DRIVE_BIT, pad_eight_milliamp_drive_bit))
        else $error("eight mA write not at pads");
    pull_up_lat_a: assert property (lands(`GPCFG_OFS_PUR, pad_pull_up))
        else $error("pull up write not at pads");
    pull_dn_lat_a: assert property (lands(`GPCFG_OFS_PDR, pad_pull_down))
        else $error("pull down write not at pads");
    od_lat_a: assert property (lands(`GPCFG_OFS_ODR, pad_open_drain))
        else $error("open drain write not at pads");
    input_en_lat_a: assert property (lands(`GPCFG_OFS_DEN, pad_input_enable))
        else $error("input enable write not at pads");
    periph_lat_a: assert property (lands(`GPCFG_OFS_AFSEL, pad_periph_ctrl))
        else $error("peripheral select not at pads");
    slverr_map_a: assert property (psel && penable |-> pslverr == !hit)
        else $error("error response wrong for address");
endmodule
bind gpcfg_top gpcfg_chk gpcfg_chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pslverr, .pad_two_milliamp_drive_bit, .pad_four_milliamp_drive_bit, .pad_eight_milliamp_drive_bit,
    .pad_open_drain, .pad_od_output, .pad_pull_up, .pad_pull_down,
    .pad_slew_limit, .pad_input_enable, .pad_periph_ctrl);
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the pad configuration block
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_params.svh"
module tb_top;
    import gpcfg_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0]  paddr, pwdata, prdata, rd;
    logic [7:0]   pad_two_milliamp_drive_bit, pad_four_milliamp_drive_bit, pad_eight_milliamp_drive_bit, pad_open_drain;
    logic [7:0]   pad_od_output, pad_pull_up, pad_pull_down;
    logic [7:0]   pad_slew_limit, pad_input_enable, pad_periph_ctrl;
    gpcfg_drive_t drive_sel_pin0;
    logic [7:0]   m [0:9];
    logic [7:0]   p [0:9];
    int           errors = 0, samples_checked = 0, cycles = 0;

    gpcfg_top gpcfg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pad_two_milliamp_drive_bit, .pad_four_milliamp_drive_bit, .pad_eight_milliamp_drive_bit,
        .pad_open_drain, .pad_od_output, .pad_pull_up, .pad_pull_down,
        .pad_slew_limit, .pad_input_enable, .pad_periph_ctrl, .drive_sel_pin0);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] ofs(input int i);
        if (i == 8) return {20'h0, `GPCFG_OFS_DIR};
        if (i == 9) return {20'h0, `GPCFG_OFS_AFSEL};
        return {20'h0, `GPCFG_OFS_TWO_MILLIAMP_DRIVE_BIT} + 32'(4 * i);
    endfunction

    function automatic gpcfg_drive_t sel();
        if (m[0][0]) return GPCFG_DRV_2MA;
        if (m[1][0]) return GPCFG_DRV_4MA;
        if (m[2][0]) return GPCFG_DRV_8MA;
        return GPCFG_DRV_NONE;
    endfunction

    // One APB transfer, held until pready
    task automatic xfer(input logic w, input logic [31:0] a, d);
        int waits = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            waits++;
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("wait_states", 32'(waits), 32'h0);
    endtask

    task automatic pads(input logic [7:0] e [0:9]);
        check("pad_two_milliamp_drive_bit", 32'(pad_two_milliamp_drive_bit), 32'(e[0]));
        check("pad_four_milliamp_drive_bit", 32'(pad_four_milliamp_drive_bit), 32'(e[1]));
        check("pad_eight_milliamp_drive_bit", 32'(pad_eight_milliamp_drive_bit), 32'(e[2]));
        check("pad_open_drain", 32'(pad_open_drain), 32'(e[3]));
        check("pad_od_output", 32'(pad_od_output), 32'(e[3] & e[8]));
        check("pad_pull_up", 32'(pad_pull_up), 32'(e[4]));
        check("pad_pull_down", 32'(pad_pull_down), 32'(e[5]));
        check("pad_slew", 32'(pad_slew_limit), 32'(e[6] & e[2]));
        check("pad_input", 32'(pad_input_enable), 32'(e[7]));
        check("pad_periph", 32'(pad_periph_ctrl), 32'(e[9]));
    endtask

    // Write, then pads old on the first cycle and new on the second
    task automatic wr(input int i, input logic [7:0] d);
        p = m;
        m[i] = d;
        for (int k = 0; k < 3; k++) begin
            if (i < 3 && k != i) m[k] &= ~d;
        end
        if (i == 4) m[5] &= ~d;
        if (i == 5) m[4] &= ~d;
        xfer(1'b1, ofs(i), {24'hA5A5A5, d});
        check("wr_err", 32'(er), 32'h0);
        @(negedge pclk);
        pads(p);
        check("drive_sel", 32'(drive_sel_pin0), 32'(sel()));
        @(negedge pclk);
        pads(m);
    endtask

    task automatic rd_all();
        for (int i = 0; i < 10; i++) begin
            xfer(1'b0, ofs(i), 32'h0);
            check("rdata", rd, 32'(m[i]));
            check("rd_err", 32'(er), 32'h0);
        end
    endtask

    task automatic t_drive();
        wr(2, 8'h0F);
        wr(1, 8'h3D);
        wr(0, 8'hC1);
        rd_all();
        wr(0, 8'hC0);
    endtask

    task automatic t_pads();
        wr(5, 8'h0F);
        wr(4, 8'h03);
        wr(3, 8'h55);
        wr(7, 8'h55);
        wr(8, 8'h0F);
        wr(3, 8'h00);
        wr(6, 8'hFF);
        wr(2, 8'hF0);
        wr(9, 8'h0C);
        wr(7, 8'hFE);
        rd_all();
    endtask

    task automatic t_bad();
        logic [31:0] a [3] = '{32'h524, 32'h1500, 32'h501};
        foreach (a[i]) begin
            xfer(1'b1, a[i], 32'hFF);
            check("wr_bad_err", 32'(er), 32'h1);
            xfer(1'b0, a[i], 32'h0);
            check("rd_bad_err", 32'(er), 32'h1);
            check("rd_bad", rd, 32'h0);
        end
        rd_all();
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        m = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF,
              8'h00, 8'h00};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        pads(m);
        rd_all();
        t_drive();
        t_pads();
        t_bad();
        final_report();
    end
endmodule
`default_nettype wire
